/* File: logic/ulcd_pkg.sv */
// Constants, types and helpers shared by the line control block
package ulcd_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [31:0] ADDR_DATA  = 32'hFFFF0700;
  localparam logic [31:0] ADDR_DIVHI = 32'hFFFF0704;
  localparam logic [31:0] ADDR_LCR0  = 32'hFFFF070C;
  localparam logic [31:0] ADDR_LCR1  = 32'hFFFF0710;
  localparam logic [31:0] ADDR_STAT  = 32'hFFFF071C;

  // ==========================================================
  // Field positions, masks and reset values
  localparam int DIVISOR_ACCESS_BIT_BIT  = 7;
  localparam int BRK_BIT   = 6;
  localparam int SP_BIT    = 5;
  localparam int EPS_BIT   = 4;
  localparam int PEN_BIT   = 3;
  localparam int STOP_BIT  = 2;
  localparam int LOOP_BIT  = 4;
  localparam int RTS_BIT   = 1;
  localparam int DTR_BIT   = 0;
  localparam int ST_DR     = 0;
  localparam int ST_PE     = 2;
  localparam int ST_FE     = 3;
  localparam int ST_THRE   = 5;
  localparam int ST_TEMT   = 6;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] IEN_MASK  = 8'h0F;
  localparam logic [7:0] LCR1_MASK = 8'h13;

  // ==========================================================
  // Timing counts in baud ticks (sixteen ticks per bit)
  localparam logic [5:0] OVS_LAST    = 6'h0F;
  localparam logic [5:0] HALF_LAST   = 6'h07;
  localparam logic [5:0] STOP1_LAST  = 6'h0F;
  localparam logic [5:0] STOP15_LAST = 6'h17;
  localparam logic [5:0] STOP2_LAST  = 6'h1F;

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    FR_IDLE  = 5'h01,
    FR_START = 5'h02,
    FR_DATA  = 5'h04,
    FR_PAR   = 5'h08,
    FR_STOP  = 5'h10
  } ulcd_frame_t;

  typedef struct packed {
    logic [1:0] wordLen;
    logic       stopLong;
    logic       parityEn;
    logic       evenSel;
    logic       stick;
  } ulcd_cfg_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
  } ulcd_req_t;

  // ==========================================================
  // Helpers
  function automatic logic [2:0] lastBit(input logic [1:0] wl);
    return {1'b1, wl};
  endfunction

  function automatic logic parityBit(input logic [7:0] d,
                                     input ulcd_cfg_t c);
    logic [7:0] m;
    m = 8'hFF >> (2'd3 - c.wordLen);
    if (c.stick) begin
      return c.evenSel;
    end
    return (^(d & m)) ^ ~c.evenSel;
  endfunction

  function automatic logic [5:0] stopLast(input ulcd_cfg_t c);
    if (!c.stopLong) begin
      return STOP1_LAST;
    end
    return (c.wordLen == 2'h0) ? STOP15_LAST : STOP2_LAST;
  endfunction

endpackage

/* File: logic/ulcd_tx.sv */
// Character serialiser for the transmit direction
`timescale 1ns/1ps
module ulcd_tx import ulcd_pkg::*; (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       baudTick,
  input  wire logic       startReq,
  input  wire logic [7:0] txData,
  input  wire ulcd_cfg_t  cfg,
  output      logic       serialOut,
  output      logic       busy
);
  ulcd_frame_t stateReg, stateNext;
  logic [5:0]  cntReg, cntNext;
  logic [2:0]  idxReg, idxNext;
  logic [7:0]  shReg, shNext;
  logic        parReg, parNext;
  logic        bitEnd;

  always_comb begin
    stateNext = stateReg;
    cntNext   = cntReg;
    idxNext   = idxReg;
    shNext    = shReg;
    parNext   = parReg;
    bitEnd    = 1'b0;
    if (baudTick) begin
      cntNext = cntReg + 6'h01;
    end
    case (stateReg)
      FR_IDLE: begin
        cntNext = 6'h00;
        if (startReq) begin
          shNext    = txData;
          parNext   = parityBit(txData, cfg);
          stateNext = FR_START;
        end
      end
      FR_START: begin
        bitEnd = baudTick && cntReg == OVS_LAST;
        if (bitEnd) begin
          stateNext = FR_DATA;
          idxNext   = 3'h0;
        end
      end
      FR_DATA: begin
        bitEnd = baudTick && cntReg == OVS_LAST;
        if (bitEnd) begin
          shNext  = shReg >> 1;
          idxNext = idxReg + 3'h1;
          if (idxReg == lastBit(cfg.wordLen)) begin
            stateNext = cfg.parityEn ? FR_PAR : FR_STOP;
          end
        end
      end
      FR_PAR: begin
        bitEnd = baudTick && cntReg == OVS_LAST;
        if (bitEnd) begin
          stateNext = FR_STOP;
        end
      end
      FR_STOP: begin
        bitEnd = baudTick && cntReg == stopLast(cfg);
        if (bitEnd) begin
          stateNext = FR_IDLE;
        end
      end
      default: stateNext = FR_IDLE;
    endcase
    if (bitEnd) begin
      cntNext = 6'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stateReg <= FR_IDLE;
      cntReg   <= 6'h00;
      idxReg   <= 3'h0;
      shReg    <= 8'h00;
      parReg   <= 1'b0;
    end else begin
      stateReg <= stateNext;
      cntReg   <= cntNext;
      idxReg   <= idxNext;
      shReg    <= shNext;
      parReg   <= parNext;
    end
  end

  assign busy      = stateReg != FR_IDLE;
  assign serialOut = (stateReg == FR_START) ? 1'b0 :
                     (stateReg == FR_DATA)  ? shReg[0] :
                     (stateReg == FR_PAR)   ? parReg : 1'b1;

  stick_par_a: assert property (@(posedge clk_sys) disable iff (rst)
    stateReg == FR_PAR && cfg.stick |-> serialOut == cfg.evenSel)
    else $error("stick parity bit wrong");
  no_par_a: assert property (@(posedge clk_sys) disable iff (rst)
    stateReg == FR_DATA && bitEnd && !cfg.parityEn
    && idxReg == lastBit(cfg.wordLen) |=> stateReg == FR_STOP)
    else $error("parity bit sent while disabled");
endmodule

/* File: logic/ulcd_rx.sv */
// Character deserialiser for the receive direction
`timescale 1ns/1ps
module ulcd_rx import ulcd_pkg::*; (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       baudTick,
  input  wire logic       serialIn,
  input  wire ulcd_cfg_t  cfg,
  output      logic [7:0] rxData,
  output      logic       rxDone,
  output      logic       parErr,
  output      logic       frmErr
);
  ulcd_frame_t stateReg, stateNext;
  logic [5:0]  cntReg, cntNext;
  logic [2:0]  idxReg, idxNext;
  logic [7:0]  shReg, shNext;
  logic        doneNext, peNext, feNext;
  logic        bitEnd;
  logic        lineReg;

  always_comb begin
    stateNext = stateReg;
    cntNext   = (baudTick) ? cntReg + 6'h01 : cntReg;
    idxNext   = idxReg;
    shNext    = shReg;
    doneNext  = 1'b0;
    peNext    = parErr;
    feNext    = frmErr;
    bitEnd    = baudTick && cntReg == OVS_LAST;
    case (stateReg)
      FR_IDLE: begin
        cntNext = 6'h00;
        // Falling edge only, so a low stop bit cannot restart the frame
        if (!serialIn && lineReg) begin
          stateNext = FR_START;
        end
      end
      FR_START: begin
        if (baudTick && cntReg == HALF_LAST) begin
          cntNext   = 6'h00;
          idxNext   = 3'h0;
          peNext    = 1'b0;
          stateNext = serialIn ? FR_IDLE : FR_DATA;
        end
      end
      FR_DATA: begin
        if (bitEnd) begin
          shNext  = {serialIn, shReg[7:1]};
          idxNext = idxReg + 3'h1;
          if (idxReg == lastBit(cfg.wordLen)) begin
            shNext    = {serialIn, shReg[7:1]} >>
                        (3'd7 - lastBit(cfg.wordLen));
            stateNext = cfg.parityEn ? FR_PAR : FR_STOP;
          end
        end
      end
      FR_PAR: begin
        if (bitEnd) begin
          peNext    = serialIn != parityBit(shReg, cfg);
          stateNext = FR_STOP;
        end
      end
      FR_STOP: begin
        if (bitEnd) begin
          feNext    = !serialIn;
          doneNext  = 1'b1;
          stateNext = FR_IDLE;
        end
      end
      default: stateNext = FR_IDLE;
    endcase
    if (bitEnd) begin
      cntNext = 6'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stateReg <= FR_IDLE;
      cntReg   <= 6'h00;
      idxReg   <= 3'h0;
      shReg    <= 8'h00;
      rxDone   <= 1'b0;
      parErr   <= 1'b0;
      frmErr   <= 1'b0;
      lineReg  <= 1'b1;
    end else begin
      stateReg <= stateNext;
      cntReg   <= cntNext;
      idxReg   <= idxNext;
      shReg    <= shNext;
      rxDone   <= doneNext;
      parErr   <= peNext;
      frmErr   <= feNext;
      lineReg  <= serialIn;
    end
  end

  assign rxData = shReg;

  first_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
    stateReg == FR_STOP && bitEnd |=> rxDone && frmErr == !$past(serialIn)
    && stateReg == FR_IDLE)
    else $error("stop bit not checked once");
endmodule

/* File: logic/ulcd_line_ctrl.sv */
// Line control, divisor and serial pin logic behind an AHB-Lite slave
// ==========================================================
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
module ulcd_line_ctrl import ulcd_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic [31:0] hrdata,
  output      logic        hresp,
  input  wire logic        rxPin,
  output      logic        txPin,
  output      logic        rtsN,
  output      logic        dtrN
);
  // ==========================================================
  // Registers
  logic [7:0]  divLoReg, divLoNext;
  logic [7:0]  divHiReg, divHiNext;
  logic [7:0]  lcr0Reg, lcr0Next;
  logic [7:0]  lcr1Reg, lcr1Next;
  logic [7:0]  ienReg, ienNext;
  logic [7:0]  thrReg, thrNext;
  logic        thrFullReg, thrFullNext;
  logic [7:0]  rbrReg, rbrNext;
  logic        drReg, drNext;
  logic        peReg, peNext;
  logic        feReg, feNext;
  ulcd_req_t   reqReg, reqNext;
  logic        pendReg, pendNext;
  logic        hreadyoutNext;
  logic [31:0] hrdataNext;
  logic        txPinNext, rtsNNext, dtrNNext;
  logic [16:0] baudCntReg, baudCntNext;
  logic        tickReg, tickNext;
  logic        rxSync1Reg, rxSync2Reg;

  // ==========================================================
  // Internal wires
  ulcd_cfg_t   cfg;
  logic        accept, wrStb, rdStb, rdRbr, divisor_access_bit;
  logic        txStart, txBusy, txSerial, rxIn;
  logic [7:0]  rxData;
  logic        rxDone, rxParErr, rxFrmErr;
  logic [15:0] divisor;
  logic [16:0] baudLimit;
  logic [7:0]  statusByte;
  logic [7:0]  wByte;

  assign divisor_access_bit    = lcr0Reg[DIVISOR_ACCESS_BIT_BIT];
  assign divisor = {divHiReg, divLoReg};
  assign cfg     = '{wordLen:  lcr0Reg[1:0],
                     stopLong: lcr0Reg[STOP_BIT],
                     parityEn: lcr0Reg[PEN_BIT],
                     evenSel:  lcr0Reg[EPS_BIT],
                     stick:    lcr0Reg[SP_BIT] & lcr0Reg[PEN_BIT]};

  // ==========================================================
  // Bus handshake: one wait cycle, then registered answer
  assign accept = hsel && htrans[1] && hready;
  assign wrStb  = pendReg && reqReg.write;
  assign rdStb  = pendReg && !reqReg.write;
  assign rdRbr  = rdStb && reqReg.addr == ADDR_DATA && !divisor_access_bit;
  assign wByte  = hwdata[7:0];

  always_comb begin
    statusByte         = 8'h00;
    statusByte[ST_DR]  = drReg;
    statusByte[ST_PE]  = peReg;
    statusByte[ST_FE]  = feReg;
    statusByte[ST_THRE] = !thrFullReg;
    statusByte[ST_TEMT] = !thrFullReg && !txBusy;
  end

  always_comb begin
    reqNext       = reqReg;
    pendNext      = 1'b0;
    hreadyoutNext = 1'b1;
    hrdataNext    = hrdata;
    if (accept) begin
      reqNext       = '{addr: haddr, write: hwrite};
      pendNext      = 1'b1;
      hreadyoutNext = 1'b0;
    end
    if (rdStb) begin
      case (reqReg.addr)
        ADDR_DATA:  hrdataNext = {24'h0, divisor_access_bit ? divLoReg : rbrReg};
        ADDR_DIVHI: hrdataNext = {24'h0, divisor_access_bit ? divHiReg : ienReg};
        ADDR_LCR0:  hrdataNext = {24'h0, lcr0Reg};
        ADDR_LCR1:  hrdataNext = {24'h0, lcr1Reg};
        ADDR_STAT:  hrdataNext = {24'h0, statusByte};
        default:    hrdataNext = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Register writes
  always_comb begin
    divLoNext = divLoReg;
    divHiNext = divHiReg;
    lcr0Next  = lcr0Reg;
    lcr1Next  = lcr1Reg;
    ienNext   = ienReg;
    thrNext   = thrReg;
    thrFullNext = thrFullReg && !txStart;
    if (wrStb) begin
      case (reqReg.addr)
        ADDR_DATA: begin
          if (divisor_access_bit) begin
            divLoNext = wByte;
          end else begin
            thrNext     = wByte;
            thrFullNext = 1'b1;
          end
        end
        ADDR_DIVHI: begin
          if (divisor_access_bit) begin
            divHiNext = wByte;
          end else begin
            ienNext = wByte & IEN_MASK;
          end
        end
        ADDR_LCR0: lcr0Next = wByte;
        ADDR_LCR1: lcr1Next = wByte & LCR1_MASK;
        default:   lcr0Next = lcr0Reg;
      endcase
    end
  end

  // ==========================================================
  // Receive flags: a new character wins over a clearing read
  always_comb begin
    rbrNext = rxDone ? rxData : rbrReg;
    drNext  = rxDone || (drReg && !rdRbr);
    peNext  = (rxDone && rxParErr) || (peReg && !rdRbr);
    feNext  = (rxDone && rxFrmErr) || (feReg && !rdRbr);
  end

  // ==========================================================
  // Baud tick at sixteen times the bit rate
  assign baudLimit = {divisor, 1'b0} - 17'h00001;

  always_comb begin
    baudCntNext = baudCntReg + 17'h00001;
    tickNext    = 1'b0;
    if (divisor == 16'h0000) begin
      baudCntNext = 17'h00000;
    end else if (baudCntReg >= baudLimit) begin
      baudCntNext = 17'h00000;
      tickNext    = 1'b1;
    end
  end

  // ==========================================================
  // Serial pins and transmit start
  assign txStart = thrFullReg && !txBusy;
  assign rxIn    = lcr1Reg[LOOP_BIT] ? txSerial : rxSync2Reg;

  always_comb begin
    txPinNext = txSerial;
    if (lcr1Reg[LOOP_BIT]) begin
      txPinNext = 1'b1;
    end else if (lcr0Reg[BRK_BIT]) begin
      txPinNext = 1'b0;
    end
    rtsNNext = !lcr1Reg[RTS_BIT];
    dtrNNext = !lcr1Reg[DTR_BIT];
  end

  // ==========================================================
  // State registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divLoReg   <= RST_BYTE;
      divHiReg   <= RST_BYTE;
      lcr0Reg    <= RST_BYTE;
      lcr1Reg    <= RST_BYTE;
      ienReg     <= RST_BYTE;
      thrReg     <= RST_BYTE;
      thrFullReg <= 1'b0;
      rbrReg     <= RST_BYTE;
      drReg      <= 1'b0;
      peReg      <= 1'b0;
      feReg      <= 1'b0;
      reqReg     <= '{addr: 32'h0, write: 1'b0};
      pendReg    <= 1'b0;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0;
      hresp      <= 1'b0;
      txPin      <= 1'b1;
      rtsN       <= 1'b1;
      dtrN       <= 1'b1;
      baudCntReg <= 17'h00000;
      tickReg    <= 1'b0;
      rxSync1Reg <= 1'b1;
      rxSync2Reg <= 1'b1;
    end else begin
      divLoReg   <= divLoNext;
      divHiReg   <= divHiNext;
      lcr0Reg    <= lcr0Next;
      lcr1Reg    <= lcr1Next;
      ienReg     <= ienNext;
      thrReg     <= thrNext;
      thrFullReg <= thrFullNext;
      rbrReg     <= rbrNext;
      drReg      <= drNext;
      peReg      <= peNext;
      feReg      <= feNext;
      reqReg     <= reqNext;
      pendReg    <= pendNext;
      hreadyout  <= hreadyoutNext;
      hrdata     <= hrdataNext;
      hresp      <= 1'b0;
      txPin      <= txPinNext;
      rtsN       <= rtsNNext;
      dtrN       <= dtrNNext;
      baudCntReg <= baudCntNext;
      tickReg    <= tickNext;
      rxSync1Reg <= rxPin;
      rxSync2Reg <= rxSync1Reg;
    end
  end

  // ==========================================================
  // Serial engines
  ulcd_tx u_tx (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .baudTick  (tickReg),
    .startReq  (txStart),
    .txData    (thrReg),
    .cfg       (cfg),
    .serialOut (txSerial),
    .busy      (txBusy)
  );

  ulcd_rx u_rx (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .baudTick (tickReg),
    .serialIn (rxIn),
    .cfg      (cfg),
    .rxData   (rxData),
    .rxDone   (rxDone),
    .parErr   (rxParErr),
    .frmErr   (rxFrmErr)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence divRead_s;
    rdStb && reqReg.addr == ADDR_DIVHI && divisor_access_bit;
  endsequence

  sequence dataWrite_s;
    wrStb && reqReg.addr == ADDR_DATA && !divisor_access_bit;
  endsequence

  divhi_read_a: assert property (divRead_s |=>
    hrdata == {24'h0, $past(divHiReg)} && hreadyout)
    else $error("high divisor readback wrong");
  divisor_access_bit_write_a: assert property (wrStb && reqReg.addr == ADDR_DATA
    && divisor_access_bit |=> divLoReg == $past(wByte)
    && thrFullReg == $past(thrFullReg && !txStart))
    else $error("low divisor write lost");
  thr_route_a: assert property (dataWrite_s |=>
    $stable(divLoReg) && thrFullReg && thrReg == $past(wByte))
    else $error("data write reached divisor");
  break_pin_a: assert property (lcr0Reg[BRK_BIT]
    && !lcr1Reg[LOOP_BIT] |=> !txPin)
    else $error("break not driving pin low");
  loop_pin_a: assert property (lcr1Reg[LOOP_BIT] |=> txPin [*2]
    or !lcr1Reg[LOOP_BIT])
    else $error("loopback pin not high");
  rts_pin_a: assert property (##1 rtsN == !$past(lcr1Reg[RTS_BIT]))
    else $error("request-to-send level wrong");
  dtr_pin_a: assert property (##1 dtrN == !$past(lcr1Reg[DTR_BIT]))
    else $error("terminal-ready level wrong");
  baud_two_a: assert property (tickReg && divisor == 16'h0001
    && $stable(divisor) |=> !tickReg ##1 tickReg)
    else $error("tick period not twice divisor");
  loop_rx_a: assert property (lcr1Reg[LOOP_BIT] |-> rxIn == txSerial)
    else $error("loopback not routed to receiver");
  bus_wait_a: assert property (accept |=> !hreadyout ##1 hreadyout)
    else $error("bus answer timing wrong");

  sequence dataRead_s;
    rdStb && reqReg.addr == ADDR_DATA && !divisor_access_bit;
  endsequence

  rbr_read_a: assert property (dataRead_s |=>
    hrdata == {24'h0, $past(rbrReg)})
    else $error("receive buffer readback wrong");
  dr_clear_a: assert property (dataRead_s ##0 !rxDone |=> !drReg)
    else $error("data ready not cleared by read");
  divlo_read_a: assert property (rdStb && reqReg.addr == ADDR_DATA
    && divisor_access_bit |=> hrdata == {24'h0, $past(divLoReg)})
    else $error("low divisor readback wrong");
  tx_normal_a: assert property (!lcr0Reg[BRK_BIT]
    && !lcr1Reg[LOOP_BIT] |=> txPin == $past(txSerial))
    else $error("transmit pin not following stream");
endmodule

/* File: verification/ulcd_remote.sv */
// Remote serial device model facing the line control block
`timescale 1ns/1ps
module ulcd_remote (
  input  wire logic        clk_sys,
  input  wire logic        txPin,
  input  wire logic [3:0]  capLen,
  input  wire logic [7:0]  bitCyc,
  output      logic        rxPin,
  output      logic [15:0] capBits,
  output      int          frames,
  output      int          gap
);
  time lastFall;

  // ==========================================================
  // Receiver: samples each bit in its middle, times start to start
  initial begin
    frames = 0;
    gap = 0;
    lastFall = 0;
    forever begin
      @(negedge txPin);
      gap = int'(($time - lastFall) / 25);
      lastFall = $time;
      capBits = 16'hFFFF;
      repeat (bitCyc / 2) @(posedge clk_sys);
      for (int i = 0; i < capLen; i++) begin
        if (i > 0) repeat (bitCyc) @(posedge clk_sys);
        capBits[i] = txPin;
      end
      frames++;
    end
  end

  // ==========================================================
  // Transmitter: line idles high between frames
  initial rxPin = 1'b1;

  task automatic sendFrame(input logic [31:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      rxPin <= f[i];
      repeat (bitCyc - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    rxPin <= 1'b1;
  endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the line control block
`timescale 1ns/1ps
module tb import ulcd_pkg::*;;
  logic        clk_sys;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        rxPin;
  logic        txPin;
  logic        rtsN;
  logic        dtrN;
  logic [3:0]  capLen;
  logic [7:0]  bitCyc;
  logic [15:0] capBits;
  logic [31:0] two;
  int          frames;
  int          gap;
  int          mismatches;
  int          check_count;

  ulcd_line_ctrl ulcd_line_ctrl_inst (.clk_sys(clk_sys), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .rxPin(rxPin), .txPin(txPin), .rtsN(rtsN), .dtrN(dtrN));

  ulcd_remote ulcd_remote_inst (.clk_sys(clk_sys), .txPin(txPin),
    .capLen(capLen), .bitCyc(bitCyc), .rxPin(rxPin),
    .capBits(capBits), .frames(frames), .gap(gap));

  // ==========================================================
  // Reporting
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ==========================================================
  // AHB-Lite master
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [7:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitReady();
    q = hrdata;
    check("hresp", hresp, 0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rdChk(input string what, input logic [31:0] a,
                       input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    check(what, q, exp);
  endtask

  // ==========================================================
  // Expected serial frames, start bit first
  function automatic logic [15:0] mkFrame(input logic [7:0] d,
      input logic [7:0] c, input logic bp, input logic bs);
    logic [15:0] f;
    logic        p;
    int          n;
    n = 5 + c[1:0];
    f = 16'hFFFE;
    p = ~c[4];
    for (int i = 0; i < n; i++) begin
      f[i + 1] = d[i];
      p ^= d[i];
    end
    if (c[5]) p = c[4];
    if (c[3]) f[n + 1] = p ^ bp;
    f[n + 1 + c[3]] = ~bs;
    return f;
  endfunction

  // ==========================================================
  // Scenarios
  task automatic resetValues();
    check("txPin", txPin, 1);
    check("rtsN", rtsN, 1);
    check("dtrN", dtrN, 1);
    rdChk("lcr0", ADDR_LCR0, 0);
    rdChk("lcr1", ADDR_LCR1, 0);
    rdChk("ien", ADDR_DIVHI, 0);
    wr(ADDR_LCR0, 8'h80);
    rdChk("divHi", ADDR_DIVHI, 0);
    rdChk("divLo", ADDR_DATA, 0);
  endtask

  task automatic divisorMap();
    wr(ADDR_DIVHI, 8'hA5);
    rdChk("divHi", ADDR_DIVHI, 32'hA5);
    wr(ADDR_DATA, 8'h01);
    rdChk("divLo", ADDR_DATA, 32'h01);
    wr(ADDR_LCR0, 8'h03);
    wr(ADDR_DIVHI, 8'hFF);
    rdChk("ien", ADDR_DIVHI, {24'h0, IEN_MASK});
    rdChk("rxBuf", ADDR_DATA, 0);
    wr(32'hFFFF0708, 8'h5A);
    rdChk("unmapped", 32'hFFFF0708, 0);
    wr(ADDR_LCR0, 8'h83);
    rdChk("divHi", ADDR_DIVHI, 32'hA5);
    wr(ADDR_DIVHI, 8'h00);
    wr(ADDR_LCR0, 8'h03);
    rdChk("ien", ADDR_DIVHI, 32'h0F);
  endtask

  task automatic modemPins();
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_LCR1, {6'h3B, v[1:0]});
      repeat (2) @(posedge clk_sys);
      check("rtsN", rtsN, !v[1]);
      check("dtrN", dtrN, !v[0]);
      rdChk("lcr1", ADDR_LCR1, v);
    end
    wr(ADDR_LCR1, 8'h00);
  endtask

  task automatic waitFrames(input int target);
    int k;
    k = 0;
    while (frames < target && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    if (frames < target) begin
      mismatches++;
      results();
    end
  endtask

  task automatic txCase(input logic [7:0] c, input int dv);
    int n;
    int k;
    int f0;
    wr(ADDR_LCR0, 8'h80);
    wr(ADDR_DATA, 8'(dv));
    wr(ADDR_LCR0, c);
    bitCyc = 8'(32 * dv);
    capLen = 4'(7 + c[1:0] + c[3]);
    f0 = frames;
    wr(ADDR_DATA, 8'hB7);
    wr(ADDR_DATA, 8'hB7);
    waitFrames(f0 + 2);
    // First start bit has a free tick phase; time the next, gapless one
    wr(ADDR_DATA, 8'hB7);
    waitFrames(f0 + 3);
    n = 5 + c[1:0];
    k = !c[2] ? 32 : (n == 5 ? 48 : 64);
    check("frame", capBits, mkFrame(8'hB7, c, 0, 0));
    check("gap", gap, ((1 + n + c[3]) * 32 + k) * dv);
    repeat (80 * dv) @(posedge clk_sys);
  endtask

  task automatic rxFrame(input logic [7:0] c, input logic [31:0] f,
      input int n, input logic [7:0] st, input logic [7:0] d);
    wr(ADDR_LCR0, c);
    ulcd_remote_inst.sendFrame(f, n);
    repeat (40) @(posedge clk_sys);
    rdChk("status", ADDR_STAT, st | 8'h60);
    rdChk("rxBuf", ADDR_DATA, d);
  endtask

  task automatic loopback();
    int lows;
    wr(ADDR_LCR0, 8'h03);
    wr(ADDR_LCR1, 8'h10);
    wr(ADDR_DATA, 8'h96);
    lows = 0;
    repeat (400) begin
      @(posedge clk_sys);
      if (txPin !== 1'b1) lows++;
    end
    check("txLow", lows, 0);
    rdChk("lbData", ADDR_DATA, 32'h96);
    wr(ADDR_LCR0, 8'h43);
    repeat (2) @(posedge clk_sys);
    check("loopBrk", txPin, 1);
    wr(ADDR_LCR1, 8'h00);
    repeat (2) @(posedge clk_sys);
    check("brk", txPin, 0);
    wr(ADDR_LCR0, 8'h03);
    repeat (2) @(posedge clk_sys);
    check("idle", txPin, 1);
  endtask

  // ==========================================================
  // Clock and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    capLen = 4'hB;
    bitCyc = 8'h20;
    mismatches = 0;
    check_count = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    resetValues();
    divisorMap();
    modemPins();
    txCase(8'h0D, 2);
    txCase(8'h03, 1);
    txCase(8'h1A, 1);
    txCase(8'h3C, 1);
    txCase(8'h2B, 1);
    rxFrame(8'h1B, mkFrame(8'h3C, 8'h1B, 0, 0), 11, 8'h01, 8'h3C);
    rxFrame(8'h1B, mkFrame(8'h3C, 8'h1B, 1, 0), 11, 8'h05, 8'h3C);
    rxFrame(8'h3B, mkFrame(8'h3C, 8'h3B, 0, 0), 11, 8'h01, 8'h3C);
    rxFrame(8'h1B, mkFrame(8'h3C, 8'h1B, 0, 1), 11, 8'h09, 8'h3C);
    two = (32'(mkFrame(8'hC3, 8'h1F, 0, 0)) << 11)
        | (mkFrame(8'h3C, 8'h1F, 0, 0) & 16'h07FF);
    rxFrame(8'h1F, two, 22, 8'h01, 8'hC3);
    loopback();
    results();
  end
endmodule
